// *** bdm_consts.vh ***
// Constants for the banked data memory map
`ifndef BDM_CONSTS_VH
`define BDM_CONSTS_VH

// Bank select position in the processor status register
`define BDM_BANK_BIT 5

// Special function register window
`define BDM_SFR_SPAN 8'h20
`define BDM_BANK1_BASE 8'h80

// Offsets (bank 0 / bank 1)
`define BDM_OFS_INDIRECT 8'h00
`define BDM_OFS_TIMER0 8'h01
`define BDM_OFS_PCL 8'h02
`define BDM_OFS_STATUS 8'h03
`define BDM_OFS_POINTER 8'h04
`define BDM_OFS_PORT_A_DATA 8'h05
`define BDM_OFS_PORT_B_DATA 8'h06
`define BDM_OFS_PCLATCH 8'h0A
`define BDM_OFS_INTCTL 8'h0B
`define BDM_OFS_PIFLAGS 8'h0C
`define BDM_OFS_CMPCTL 8'h1F
`define BDM_OFS_OPTION 8'h81
`define BDM_OFS_PADIR 8'h85
`define BDM_OFS_PBDIR 8'h86
`define BDM_OFS_PIENA 8'h8C
`define BDM_OFS_PWRCTL 8'h8E
`define BDM_OFS_EEIF 8'h90
`define BDM_OFS_VREFCTL 8'h9F

// General purpose RAM windows
`define BDM_GPR0_LO 8'h20
`define BDM_GPR0_HI 8'h7F
`define BDM_GPR1_LO 8'hA0
`define BDM_GPR1_HI 8'hBF
`define BDM_COMMON_LO 8'hF0
`define BDM_COMMON_HI 8'hFF
`define BDM_COMMON_ALIAS 8'h70
`define BDM_GPR_SMALL 96
`define BDM_GPR_LARGE 128

// Reset values of the core-side registers
`define BDM_RST_PCL 8'h00
`define BDM_RST_STATUS 8'h00
`define BDM_RST_POINTER 8'h00
`define BDM_RST_PCLATCH 8'h00
`define BDM_RST_INTCTL 8'h00

// External special register select positions
`define BDM_SEL_TIMER0 0
`define BDM_SEL_PORT_A_DATA 1
`define BDM_SEL_PORT_B_DATA 2
`define BDM_SEL_PIFLAGS 3
`define BDM_SEL_CMPCTL 4
`define BDM_SEL_OPTION 5
`define BDM_SEL_PADIR 6
`define BDM_SEL_PBDIR 7
`define BDM_SEL_PIENA 8
`define BDM_SEL_PWRCTL 9
`define BDM_SEL_EEIF 10
`define BDM_SEL_VREFCTL 11
`define BDM_SEL_COUNT 12

// Read source codes
`define BDM_SRC_ZERO 2'h0
`define BDM_SRC_CORE 2'h1
`define BDM_SRC_SFR 2'h2
`define BDM_SRC_GPR 2'h3

`endif

// *** bdm_addr_decode.v ***
// Region decoder for the banked data memory map
`timescale 1ns/10ps
`include "bdm_consts.vh"

module bdm_addr_decode #(
  parameter LARGE_VARIANT = 0
) (
  // Effective 8-bit file address
  input wire [7:0] i_addr,
  // Region hits
  output reg o_indirect_hit,
  output reg o_sfr_window,
  output reg o_gpr_hit,
  output reg [6:0] o_gpr_idx
);

  always @* begin
    o_indirect_hit = 1'b0;
    o_sfr_window = 1'b0;
    o_gpr_hit = 1'b0;
    o_gpr_idx = 7'h00;
    if (i_addr[6:0] < `BDM_SFR_SPAN) begin
      o_sfr_window = 1'b1; // [RULE2]
      o_indirect_hit = (i_addr[6:0] == `BDM_OFS_INDIRECT); // [RULE7]
    end else if (i_addr >= `BDM_GPR0_LO && i_addr <= `BDM_GPR0_HI) begin
      o_gpr_hit = 1'b1; // [RULE3]
      o_gpr_idx = i_addr[6:0] - 7'h20;
    end else if (i_addr >= `BDM_COMMON_LO) begin
      o_gpr_hit = 1'b1; // [RULE4]
      o_gpr_idx = {3'h5, i_addr[3:0]};
    end else if (LARGE_VARIANT != 0 && i_addr >= `BDM_GPR1_LO && i_addr <= `BDM_GPR1_HI) begin
      o_gpr_hit = 1'b1; // [RULE3]
      o_gpr_idx = {2'h3, i_addr[4:0]};
    end
  end

endmodule // bdm_addr_decode

// *** bdm_gpr_ram.v ***
// General purpose static RAM array
`timescale 1ns/10ps

module bdm_gpr_ram #(
  parameter DEPTH = 96,
  parameter AW = 7
) (
  // Clock
  input wire i_clk,
  // Access
  input wire i_we,
  input wire [AW-1:0] i_idx,
  input wire [7:0] i_wdata,
  output wire [7:0] o_rdata
);

  reg [7:0] mem_r [0:DEPTH-1];

  always @(posedge i_clk) begin
    if (i_we) begin
      mem_r[i_idx] <= i_wdata; // [RULE6]
    end
  end

  assign o_rdata = mem_r[i_idx];

endmodule // bdm_gpr_ram

// *** bdm_data_map.v ***
// Banked data memory decoder and core register file
//
// Contract
// [RULE1] Bank 0 while status bit 5 is clear, bank 1 while it is set.
// [RULE2] Lowest 32 addresses of each bank decode as special registers.
// [RULE3] RAM at 20-7Fh always; large variant adds A0-BFh.
// [RULE4] Bank 1 F0-FFh reaches the same bytes as bank 0 70-7Fh.
// [RULE5] Every location reachable directly or through the indirect pointer.
// [RULE6] RAM holds 96 bytes, or 128 bytes on the large variant.
// [RULE7] Indirect location 00h/80h has no storage; accesses redirect.
// [RULE8] Core registers decode the same in both banks, offset 80h apart.
`timescale 1ns/10ps
`include "bdm_consts.vh"

module bdm_data_map #(
  parameter LARGE_VARIANT = 0
) (
  // Clock and reset
  input wire i_clk,
  input wire i_rst,
  // Core data access port
  input wire [6:0] i_addr,
  input wire [7:0] i_wdata,
  input wire i_wr,
  input wire i_rd,
  output reg [7:0] o_rdata,
  // Core hardware updates
  input wire [7:0] i_status_mask,
  input wire [7:0] i_status_val,
  input wire i_pcl_load,
  input wire [7:0] i_pcl_val,
  // Core register views
  output wire [7:0] o_status,
  output wire [7:0] o_pointer,
  output wire [7:0] o_pcl,
  output wire [7:0] o_pclatch,
  output wire [7:0] o_intctl,
  output wire o_bank_sel,
  output reg o_pcl_written,
  // External special registers
  output reg [`BDM_SEL_COUNT-1:0] o_sfr_sel,
  output reg o_sfr_wr,
  output reg o_sfr_rd,
  output reg [7:0] o_sfr_wdata,
  input wire [7:0] i_sfr_rdata
);

  localparam DEPTH = (LARGE_VARIANT != 0) ? `BDM_GPR_LARGE : `BDM_GPR_SMALL;
  localparam [2:0] CORE_NONE = 3'h0;
  localparam [2:0] CORE_PCL = 3'h1;
  localparam [2:0] CORE_STATUS = 3'h2;
  localparam [2:0] CORE_POINTER = 3'h3;
  localparam [2:0] CORE_PCLATCH = 3'h4;
  localparam [2:0] CORE_INTCTL = 3'h5;

  reg [7:0] status_r;
  reg [7:0] status_nxt;
  reg [7:0] pointer_r;
  reg [7:0] pcl_r;
  reg [7:0] pcl_nxt;
  reg [7:0] pclatch_r;
  reg [7:0] intctl_r;
  reg [7:0] eff_addr;
  reg [2:0] core_idx;
  reg [`BDM_SEL_COUNT-1:0] sfr_sel;
  reg [7:0] core_val;
  reg [1:0] src_nxt;
  wire direct_indirect_data_access;
  wire indirect_hit;
  wire sfr_window;
  wire gpr_hit;
  wire [6:0] gpr_idx;
  wire [7:0] gpr_rdata;
  wire gpr_we;
  wire core_hit;
  wire sfr_hit;
  wire access;

  assign access = i_wr | i_rd;

  // Effective address formation
  assign direct_indirect_data_access = (i_addr == `BDM_OFS_INDIRECT);

  always @* begin
    if (direct_indirect_data_access) begin
      eff_addr = pointer_r; // [RULE5] [RULE7]
    end else begin
      eff_addr = {status_r[`BDM_BANK_BIT], i_addr}; // [RULE1]
    end
  end

  bdm_addr_decode #(
    .LARGE_VARIANT(LARGE_VARIANT)
  ) u_decode (
    .i_addr(eff_addr),
    .o_indirect_hit(indirect_hit),
    .o_sfr_window(sfr_window),
    .o_gpr_hit(gpr_hit),
    .o_gpr_idx(gpr_idx)
  );

  // Core registers, same offset in both banks
  always @* begin
    core_idx = CORE_NONE;
    if (sfr_window && !indirect_hit) begin
      case (eff_addr[6:0])
        `BDM_OFS_PCL: begin
          core_idx = CORE_PCL; // [RULE8]
        end
        `BDM_OFS_STATUS: begin
          core_idx = CORE_STATUS; // [RULE8]
        end
        `BDM_OFS_POINTER: begin
          core_idx = CORE_POINTER; // [RULE8]
        end
        `BDM_OFS_PCLATCH: begin
          core_idx = CORE_PCLATCH; // [RULE8]
        end
        `BDM_OFS_INTCTL: begin
          core_idx = CORE_INTCTL; // [RULE8]
        end
        default: begin
          core_idx = CORE_NONE;
        end
      endcase
    end
  end

  assign core_hit = (core_idx != CORE_NONE);

  // Bank-specific special registers held outside
  always @* begin
    sfr_sel = {`BDM_SEL_COUNT{1'b0}};
    if (sfr_window && !indirect_hit) begin
      case (eff_addr)
        `BDM_OFS_TIMER0: begin
          sfr_sel[`BDM_SEL_TIMER0] = 1'b1;
        end
        `BDM_OFS_PORT_A_DATA: begin
          sfr_sel[`BDM_SEL_PORT_A_DATA] = 1'b1;
        end
        `BDM_OFS_PORT_B_DATA: begin
          sfr_sel[`BDM_SEL_PORT_B_DATA] = 1'b1;
        end
        `BDM_OFS_PIFLAGS: begin
          sfr_sel[`BDM_SEL_PIFLAGS] = 1'b1;
        end
        `BDM_OFS_CMPCTL: begin
          sfr_sel[`BDM_SEL_CMPCTL] = 1'b1;
        end
        `BDM_OFS_OPTION: begin
          sfr_sel[`BDM_SEL_OPTION] = 1'b1; // [RULE2]
        end
        `BDM_OFS_PADIR: begin
          sfr_sel[`BDM_SEL_PADIR] = 1'b1; // [RULE2]
        end
        `BDM_OFS_PBDIR: begin
          sfr_sel[`BDM_SEL_PBDIR] = 1'b1; // [RULE2]
        end
        `BDM_OFS_PIENA: begin
          sfr_sel[`BDM_SEL_PIENA] = 1'b1; // [RULE2]
        end
        `BDM_OFS_PWRCTL: begin
          sfr_sel[`BDM_SEL_PWRCTL] = 1'b1; // [RULE2]
        end
        `BDM_OFS_EEIF: begin
          sfr_sel[`BDM_SEL_EEIF] = 1'b1; // [RULE2]
        end
        `BDM_OFS_VREFCTL: begin
          sfr_sel[`BDM_SEL_VREFCTL] = 1'b1; // [RULE2]
        end
        default: begin
          sfr_sel = {`BDM_SEL_COUNT{1'b0}};
        end
      endcase
    end
  end

  assign sfr_hit = |sfr_sel;

  // General purpose RAM
  assign gpr_we = i_wr && gpr_hit;

  bdm_gpr_ram #(
    .DEPTH(DEPTH),
    .AW(7)
  ) u_ram (
    .i_clk(i_clk),
    .i_we(gpr_we),
    .i_idx(gpr_idx),
    .i_wdata(i_wdata),
    .o_rdata(gpr_rdata)
  );

  // Status: software write, then hardware flag update wins
  always @* begin
    status_nxt = status_r;
    if (i_wr && core_idx == CORE_STATUS) begin
      status_nxt = i_wdata; // [RULE1]
    end
    status_nxt = (status_nxt & ~i_status_mask) | (i_status_val & i_status_mask);
  end

  // Program counter low: core load wins over software write
  always @* begin
    pcl_nxt = pcl_r;
    if (i_wr && core_idx == CORE_PCL) begin
      pcl_nxt = i_wdata;
    end
    if (i_pcl_load) begin
      pcl_nxt = i_pcl_val;
    end
  end

  always @(posedge i_clk) begin
    if (i_rst) begin
      status_r <= `BDM_RST_STATUS;
      pcl_r <= `BDM_RST_PCL;
      pointer_r <= `BDM_RST_POINTER;
      pclatch_r <= `BDM_RST_PCLATCH;
      intctl_r <= `BDM_RST_INTCTL;
      o_pcl_written <= 1'b0;
    end else begin
      status_r <= status_nxt;
      pcl_r <= pcl_nxt;
      o_pcl_written <= i_wr && core_idx == CORE_PCL;
      if (i_wr && core_idx == CORE_POINTER) begin
        pointer_r <= i_wdata; // [RULE5]
      end
      if (i_wr && core_idx == CORE_PCLATCH) begin
        pclatch_r <= i_wdata;
      end
      if (i_wr && core_idx == CORE_INTCTL) begin
        intctl_r <= i_wdata;
      end
    end
  end

  // Core register read value
  always @* begin
    case (core_idx)
      CORE_PCL: begin
        core_val = pcl_r;
      end
      CORE_STATUS: begin
        core_val = status_r;
      end
      CORE_POINTER: begin
        core_val = pointer_r;
      end
      CORE_PCLATCH: begin
        core_val = pclatch_r;
      end
      CORE_INTCTL: begin
        core_val = intctl_r;
      end
      default: begin
        core_val = 8'h00;
      end
    endcase
  end

  // Read source; indirect self-access and holes read zero
  always @* begin
    if (core_hit) begin
      src_nxt = `BDM_SRC_CORE;
    end else if (sfr_hit) begin
      src_nxt = `BDM_SRC_SFR;
    end else if (gpr_hit) begin
      src_nxt = `BDM_SRC_GPR;
    end else begin
      src_nxt = `BDM_SRC_ZERO; // [RULE7]
    end
  end

  // Registered read data, one cycle after the strobe
  always @(posedge i_clk) begin
    if (i_rst) begin
      o_rdata <= 8'h00;
    end else begin
      if (i_rd) begin
        case (src_nxt)
          `BDM_SRC_CORE: begin
            o_rdata <= core_val;
          end
          `BDM_SRC_SFR: begin
            o_rdata <= i_sfr_rdata;
          end
          `BDM_SRC_GPR: begin
            o_rdata <= gpr_rdata; // [RULE3] [RULE4]
          end
          default: begin
            o_rdata <= 8'h00;
          end
        endcase
      end else begin
        o_rdata <= 8'h00;
      end
    end
  end

  // External special register strobes
  always @* begin
    o_sfr_sel = sfr_sel;
    o_sfr_wr = i_wr && sfr_hit;
    o_sfr_rd = i_rd && sfr_hit;
    o_sfr_wdata = i_wdata;
    if (!access) begin
      o_sfr_sel = {`BDM_SEL_COUNT{1'b0}};
    end
  end

  // Core register views
  assign o_status = status_r;
  assign o_pointer = pointer_r;
  assign o_pcl = pcl_r;
  assign o_pclatch = pclatch_r;
  assign o_intctl = intctl_r;
  assign o_bank_sel = status_r[`BDM_BANK_BIT]; // [RULE1]

endmodule // bdm_data_map

// *** bdm_sfr_model.sv ***
// Behavioural model of the external special registers
`timescale 1ns/10ps
module bdm_sfr_model (
  // Clock
  input logic i_clk,
  // Strobes and data from the map
  input logic [11:0] i_sel,
  input logic i_wr,
  input logic i_rd,
  input logic [7:0] i_wdata,
  output logic [7:0] o_rdata
);
  logic [7:0] regs [0:11];
  logic [7:0] last_r = 8'h00;
  // Read data only while selected, otherwise a changing pattern
  always_comb begin
    o_rdata = ~last_r;
    for (int k = 0; k < 12; k++) if (i_rd && i_sel[k]) o_rdata = regs[k];
  end
  always @(posedge i_clk) begin
    for (int k = 0; k < 12; k++) if (i_wr && i_sel[k]) regs[k] <= i_wdata;
    last_r <= o_rdata;
  end
endmodule // bdm_sfr_model

// *** bdm_data_map_chk.sv ***
// Assertions on the ports of the banked data memory map
`timescale 1ns/10ps
module bdm_data_map_chk (
  input logic i_clk,
  input logic i_rst,
  input logic [6:0] i_addr,
  input logic [7:0] i_wdata,
  input logic i_wr,
  input logic i_rd,
  input logic [7:0] o_rdata,
  input logic [7:0] i_status_mask,
  input logic i_pcl_load,
  input logic [7:0] o_pointer,
  input logic [7:0] o_pcl,
  input logic o_bank_sel,
  input logic [7:0] o_status,
  input logic o_pcl_written,
  input logic [11:0] o_sfr_sel,
  input logic o_sfr_wr,
  input logic o_sfr_rd,
  input logic [7:0] o_sfr_wdata,
  input logic [7:0] i_sfr_rdata
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);
  AST_BANK: assert property ((i_wr || i_rd) && i_addr == 7'h01
    |-> o_sfr_sel == (o_bank_sel ? 12'h020 : 12'h001)) else $error("bank decode");
  AST_STAT: assert property (i_wr && i_addr == 7'h03 && !i_status_mask[5]
    |=> o_bank_sel == $past(i_wdata[5])) else $error("bank write");
  AST_PORT: assert property (i_wr && i_addr == 7'h05
    |-> o_sfr_wr && o_sfr_sel == (o_bank_sel ? 12'h040 : 12'h002)) else $error("port sel");
  AST_SEL: assert property ($onehot0(o_sfr_sel) &&
    ((o_sfr_sel != 12'h000) == (o_sfr_wr || o_sfr_rd))) else $error("select");
  AST_WDAT: assert property (o_sfr_wr |-> o_sfr_wdata == i_wdata) else $error("wdata");
  AST_SFRRD: assert property (o_sfr_rd |=> o_rdata == $past(i_sfr_rdata)) else $error("sfr rd");
  AST_IDLE: assert property (!$past(i_rd) |-> o_rdata == 8'h00) else $error("idle rdata");
  AST_IND: assert property (i_rd && i_addr == 7'h00 && o_pointer == 8'h01
    |-> o_sfr_rd && o_sfr_sel == 12'h001) else $error("indirect sel");
  AST_NULL: assert property (i_rd && i_addr == 7'h00 && o_pointer[6:0] == 7'h00
    |=> o_rdata == 8'h00) else $error("indirect null");
  AST_PTR: assert property (i_wr && i_addr == 7'h04
    |=> o_pointer == $past(i_wdata)) else $error("pointer");
  AST_PCL: assert property (i_wr && i_addr == 7'h02 && !i_pcl_load
    |=> o_pcl == $past(i_wdata) && o_pcl_written) else $error("pcl");
endmodule // bdm_data_map_chk
bind bdm_data_map bdm_data_map_chk chk_u (.i_clk(i_clk), .i_rst(i_rst), .i_addr(i_addr),
  .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
  .i_status_mask(i_status_mask), .i_pcl_load(i_pcl_load), .o_pointer(o_pointer),
  .o_pcl(o_pcl), .o_bank_sel(o_bank_sel), .o_status(o_status),
  .o_pcl_written(o_pcl_written), .o_sfr_sel(o_sfr_sel), .o_sfr_wr(o_sfr_wr),
  .o_sfr_rd(o_sfr_rd), .o_sfr_wdata(o_sfr_wdata), .i_sfr_rdata(i_sfr_rdata));

// *** tb.sv ***
// Self-checking bench for the banked data memory map
`timescale 1ns/10ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin mismatches++; \
  $display("MISMATCH t=%0t got %h exp %h", $time, a, b); end end
module tb;
  logic i_clk = 1'h0, i_rst = 1'h1, i_wr = 1'h0, i_rd = 1'h0, i_pcl_load = 1'h0;
  logic [6:0] i_addr = 7'h00;
  logic [7:0] i_wdata = 8'h00, i_status_mask = 8'h00, i_status_val = 8'h00, i_pcl_val = 8'h00;
  wire [7:0] o_rdata, o_status, o_pointer, o_pcl, o_pclatch, o_intctl, o_sfr_wdata, sfr_rdata;
  wire [11:0] o_sfr_sel;
  wire o_bank_sel, o_pcl_written, o_sfr_wr, o_sfr_rd;
  wire [7:0] o_rdata_lg;
  int mismatches = 0, num_checks = 0;
  always #12.5 i_clk = ~i_clk;
  bdm_data_map #(.LARGE_VARIANT(0)) dut_u (.i_clk(i_clk), .i_rst(i_rst), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .i_status_mask(i_status_mask), .i_status_val(i_status_val), .i_pcl_load(i_pcl_load),
    .i_pcl_val(i_pcl_val), .o_status(o_status), .o_pointer(o_pointer), .o_pcl(o_pcl),
    .o_pclatch(o_pclatch), .o_intctl(o_intctl), .o_bank_sel(o_bank_sel),
    .o_pcl_written(o_pcl_written), .o_sfr_sel(o_sfr_sel), .o_sfr_wr(o_sfr_wr),
    .o_sfr_rd(o_sfr_rd), .o_sfr_wdata(o_sfr_wdata), .i_sfr_rdata(sfr_rdata));
  bdm_sfr_model sfr_u (.i_clk(i_clk), .i_sel(o_sfr_sel), .i_wr(o_sfr_wr), .i_rd(o_sfr_rd),
    .i_wdata(o_sfr_wdata), .o_rdata(sfr_rdata));
  // Large variant in lockstep, answered by the same model
  bdm_data_map #(.LARGE_VARIANT(1)) dut_lg_u (.i_clk(i_clk), .i_rst(i_rst), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata_lg),
    .i_status_mask(i_status_mask), .i_status_val(i_status_val), .i_pcl_load(i_pcl_load),
    .i_pcl_val(i_pcl_val), .o_status(), .o_pointer(), .o_pcl(), .o_pclatch(), .o_intctl(),
    .o_bank_sel(), .o_pcl_written(), .o_sfr_sel(), .o_sfr_wr(), .o_sfr_rd(), .o_sfr_wdata(),
    .i_sfr_rdata(sfr_rdata));
  task finish_test;
    $display("Checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task wr(input logic [6:0] a, input logic [7:0] d);
    @(posedge i_clk);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'h1;
    @(posedge i_clk);
    i_wr <= 1'h0;
    #1;
  endtask
  task rd_lg(input logic [6:0] a, input logic [7:0] e, input logic [7:0] el);
    @(posedge i_clk);
    i_addr <= a;
    i_rd <= 1'h1;
    @(posedge i_clk);
    i_rd <= 1'h0;
    #1;
    `CHK(o_rdata, e)
    `CHK(o_rdata_lg, el)
  endtask
  task rd(input logic [6:0] a, input logic [7:0] e);
    rd_lg(a, e, e);
  endtask
  // One write with hardware updates in the same cycle
  task hw_wr(input logic [6:0] a, input logic [7:0] d, input logic [7:0] m, input logic ld);
    @(posedge i_clk);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'h1;
    i_status_mask <= m;
    i_status_val <= 8'hFF;
    i_pcl_load <= ld;
    i_pcl_val <= 8'h9A;
    @(posedge i_clk);
    i_wr <= 1'h0;
    i_status_mask <= 8'h00;
    i_pcl_load <= 1'h0;
    #1;
  endtask
  // Bank switching and mirrored core registers
  task t_bank;
    rd(7'h03, 8'h00);
    wr(7'h03, 8'h20);
    `CHK(o_bank_sel, 1'h1)
    `CHK(o_status, 8'h20)
    wr(7'h0A, 8'h77);
    `CHK(o_pclatch, 8'h77)
    wr(7'h02, 8'h12);
    `CHK(o_pcl, 8'h12)
    wr(7'h03, 8'h00);
    `CHK(o_bank_sel, 1'h0)
    rd(7'h0A, 8'h77);
    wr(7'h0B, 8'h3C);
    `CHK(o_intctl, 8'h3C)
    wr(7'h03, 8'h20);
    rd(7'h0B, 8'h3C);
    rd(7'h02, 8'h12);
    wr(7'h03, 8'h00);
  endtask
  // RAM windows, common RAM and unimplemented places
  task t_ram;
    wr(7'h20, 8'hA1);
    wr(7'h7F, 8'hB2);
    rd(7'h20, 8'hA1);
    rd(7'h7F, 8'hB2);
    rd(7'h07, 8'h00);
    wr(7'h03, 8'h20);
    wr(7'h70, 8'h5A);
    wr(7'h20, 8'hEE);
    rd_lg(7'h20, 8'h00, 8'hEE);
    wr(7'h03, 8'h00);
    rd(7'h70, 8'h5A);
    rd(7'h20, 8'hA1);
  endtask
  // Pointer based access
  task t_ind;
    wr(7'h04, 8'hF3);
    wr(7'h00, 8'h11);
    rd(7'h73, 8'h11);
    wr(7'h04, 8'h00);
    wr(7'h00, 8'h99);
    rd(7'h00, 8'h00);
    wr(7'h04, 8'h80);
    `CHK(o_pointer, 8'h80)
    rd(7'h00, 8'h00);
  endtask
  // External special registers in both banks
  task t_sfr;
    wr(7'h05, 8'h3C);
    wr(7'h01, 8'h4E);
    wr(7'h03, 8'h20);
    wr(7'h05, 8'hC3);
    rd(7'h05, 8'hC3);
    wr(7'h01, 8'h6D);
    rd(7'h01, 8'h6D);
    wr(7'h04, 8'h01);
    rd(7'h00, 8'h4E);
    wr(7'h03, 8'h00);
    rd(7'h05, 8'h3C);
  endtask
  // Hardware status and program counter updates beside software writes
  task t_hw;
    hw_wr(7'h03, 8'h00, 8'h20, 1'h0);
    `CHK(o_status, 8'h20)
    hw_wr(7'h02, 8'h55, 8'h00, 1'h1);
    `CHK(o_pcl, 8'h9A)
    `CHK(o_pcl_written, 1'h1)
    wr(7'h02, 8'h44);
    `CHK(o_pcl, 8'h44)
    @(posedge i_clk);
    #1;
    `CHK(o_pcl_written, 1'h0)
    wr(7'h03, 8'h00);
  endtask
  // Reset in mid-run
  task t_rst;
    wr(7'h04, 8'h55);
    wr(7'h03, 8'h20);
    @(posedge i_clk);
    i_rst <= 1'h1;
    repeat (2) @(posedge i_clk);
    i_rst <= 1'h0;
    #1;
    `CHK(o_status, 8'h00)
    `CHK(o_pointer, 8'h00)
    rd(7'h04, 8'h00);
  endtask
  initial begin
    #20000;
    mismatches++;
    finish_test;
  end
  initial begin
    repeat (20) @(posedge i_clk);
    i_rst <= 1'h0;
    t_bank;
    t_ram;
    t_ind;
    t_sfr;
    t_hw;
    t_rst;
    finish_test;
  end
endmodule // tb
